/* File: hdl/host_bus_decoder.sv */
// Purpose: Device end: decodes host bus accesses into read, data write, command write
// Assumes: Straps static; strobe pins asynchronous to clock
// Notes: Pins pass two flip-flops before decoding
//
// Behaviour
// RULE1 - Straps pick generic, enable or data-strobe style
// RULE2 - Straps tied fixed by pull resistors
// RULE3 - Host drives select from address bit zero; the master drives it from the access kind, low only for a data write
// RULE4 - Read with select high returns data
// RULE5 - Write select low data, high command
// RULE6 - Generic: read low reads, write low writes
// RULE7 - Enable style: enable high, direction picks
// RULE8 - Data strobe low, direction picks access
// RULE9 - Ignore bad reads and deselected accesses
`timescale 1ns/1ps
`include "host_bus_defines.svh"
module host_bus_decoder (
	input wire logic clock,
	input wire logic reset,
	input wire logic [2:0] bus_config_straps,
	host_bus_if.device bus,
	input wire logic [7:0] read_data,
	output logic read_pulse,
	output logic data_write_pulse,
	output logic cmd_write_pulse,
	output logic [7:0] write_data
);
	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [11:0] sync1;
	logic [11:0] sync2;
	always_ff @(posedge clock) begin
		if (reset) begin
			sync1 <= 12'h001;
			sync2 <= 12'h001;
		end else begin
			sync1 <= {bus.host_data_out, bus.write_strobe, bus.read_strobe, bus.cmd_data_select, bus.chip_select_n};
			sync2 <= sync1;
		end
	end
	logic cs_n_s, cd_s, rd_s, wr_s;
	logic [7:0] din_s;
	assign {din_s, wr_s, rd_s, cd_s, cs_n_s} = sync2;

	// ---------------------------------------------
	// Strap capture
	// ---------------------------------------------
	// Sampled on every clock out of reset; straps are assumed static
	host_bus_pkg::bus_style_e style;
	always_ff @(posedge clock) begin
		if (reset) begin
			style <= host_bus_pkg::bus_generic;
		end else begin
			unique case (bus_config_straps)
				`STYLE_ENABLE: style <= host_bus_pkg::bus_enable; // RULE1 RULE2
				`STYLE_DSTROBE: style <= host_bus_pkg::bus_dstrobe; // RULE1
				default: style <= host_bus_pkg::bus_generic; // RULE1
			endcase
		end
	end

	// ---------------------------------------------
	// Access decode
	// ---------------------------------------------
	function automatic host_bus_pkg::access_e decode(input host_bus_pkg::bus_style_e s, input logic cs_n,
		input logic cd, input logic p0, input logic p1);
		logic active;
		logic is_read;
		active = 1'b0;
		is_read = 1'b0;
		unique case (s)
			host_bus_pkg::bus_generic: begin
				active = (p0 ^ p1); // RULE6
				is_read = !p0; // RULE6
			end
			host_bus_pkg::bus_enable: begin
				active = p1; // RULE7
				is_read = p0; // RULE7
			end
			host_bus_pkg::bus_dstrobe: begin
				active = !p1; // RULE8
				is_read = p0; // RULE8
			end
		endcase
		if (cs_n || !active)
			decode = host_bus_pkg::acc_none; // RULE9
		else if (is_read)
			decode = cd ? host_bus_pkg::acc_read : host_bus_pkg::acc_none; // RULE4 RULE9
		else
			decode = cd ? host_bus_pkg::acc_cmd_write : host_bus_pkg::acc_data_write; // RULE5
	endfunction

	// Read pin carries direction, write pin carries strobe outside generic style
	host_bus_pkg::access_e access;
	host_bus_pkg::access_e last_access;
	assign access = decode(style, cs_n_s, cd_s, rd_s, wr_s);
	always_ff @(posedge clock) begin
		if (reset) begin
			last_access <= host_bus_pkg::acc_none;
		end else begin
			last_access <= access;
		end
	end

	// ---------------------------------------------
	// Pulses and data
	// ---------------------------------------------
	logic start;
	assign start = (access != last_access);
	always_ff @(posedge clock) begin
		if (reset) begin
			read_pulse <= 1'b0;
			data_write_pulse <= 1'b0;
			cmd_write_pulse <= 1'b0;
			write_data <= 8'h00;
		end else begin
			read_pulse <= start && access == host_bus_pkg::acc_read; // RULE4
			data_write_pulse <= start && access == host_bus_pkg::acc_data_write; // RULE5
			cmd_write_pulse <= start && access == host_bus_pkg::acc_cmd_write; // RULE5
			if (start && (access == host_bus_pkg::acc_data_write || access == host_bus_pkg::acc_cmd_write))
				write_data <= din_s;
		end
	end

	// Drive bus only during an accepted read
	always_ff @(posedge clock) begin
		if (reset) begin
			bus.dev_data_out <= `READ_IDLE_DATA;
			bus.dev_data_oe <= 1'b0;
		end else begin
			bus.dev_data_oe <= (access == host_bus_pkg::acc_read); // RULE4 RULE9
			bus.dev_data_out <= (access == host_bus_pkg::acc_read) ? read_data : `READ_IDLE_DATA;
		end
	end
endmodule

/* File: hdl/host_bus_defines.svh */
// Purpose: Constants shared by both ends of the parallel host port
// Assumes: 100 MHz clock
// Notes: Strap codes select the bus style
`ifndef HOST_BUS_DEFINES_SVH
`define HOST_BUS_DEFINES_SVH
`define STYLE_GENERIC 3'h0
`define STYLE_ENABLE 3'h1
`define STYLE_DSTROBE 3'h2
`define CMD_DATA_BIT 0
`define STROBE_HOLD_NS 40
`define STROBE_HOLD_CYC ((`STROBE_HOLD_NS + 9) / 10)
`define READ_IDLE_DATA 8'h00
`endif

/* File: hdl/host_bus_pkg.sv */
// Purpose: Types for the parallel host port
// Assumes: Nothing
// Notes: Values of straps live in the defines header
package host_bus_pkg;
	typedef enum logic [1:0] {
		acc_none,
		acc_read,
		acc_data_write,
		acc_cmd_write
	} access_e;
	typedef enum logic [1:0] {
		bus_generic,
		bus_enable,
		bus_dstrobe
	} bus_style_e;
endpackage

/* File: hdl/host_bus_if.sv */
// Purpose: Pins between host and display controller port
// Assumes: Ends read each other's data outputs directly; no resolved data wire
// Notes: Strobe pins change meaning with bus style
`timescale 1ns/1ps
interface host_bus_if;
	logic chip_select_n;
	logic cmd_data_select;
	logic read_strobe;
	logic write_strobe;
	logic [7:0] host_data_out;
	logic host_data_oe;
	logic [7:0] dev_data_out;
	logic dev_data_oe;
	modport device (
		input chip_select_n, cmd_data_select, read_strobe, write_strobe, host_data_out, host_data_oe,
		output dev_data_out, dev_data_oe
	);
	modport host (
		output chip_select_n, cmd_data_select, read_strobe, write_strobe, host_data_out, host_data_oe,
		input dev_data_out, dev_data_oe
	);
endinterface

/* File: hdl/host_bus_master.sv */
// Purpose: Host end: runs one access per request on the parallel bus
// Assumes: Same strap code as the device end
// Notes: Strobe held a fixed count; data taken at end of strobe
`timescale 1ns/1ps
`include "host_bus_defines.svh"
module host_bus_master (
	input wire logic clock,
	input wire logic reset,
	input wire logic [2:0] bus_config_straps,
	host_bus_if.host bus,
	input wire logic req_valid,
	output logic req_ready,
	input wire host_bus_pkg::access_e req_kind,
	input wire logic [7:0] req_data,
	output logic done,
	output logic [7:0] rsp_data
);
	typedef enum logic [1:0] {st_idle, st_setup, st_strobe, st_recover} state_e;
	state_e state;
	logic [7:0] count;
	host_bus_pkg::access_e kind;
	logic [7:0] wdata;
	assign req_ready = (state == st_idle);

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= st_idle;
			count <= 8'h00;
			kind <= host_bus_pkg::acc_none;
			wdata <= 8'h00;
		end else begin
			unique case (state)
				st_idle: if (req_valid && req_kind != host_bus_pkg::acc_none) begin
					kind <= req_kind;
					wdata <= req_data;
					state <= st_setup;
				end
				st_setup: begin
					count <= 8'((`STROBE_HOLD_CYC) + 2);
					state <= st_strobe;
				end
				st_strobe: begin
					count <= count - 8'h01;
					if (count == 8'h01)
						state <= st_recover;
				end
				st_recover: state <= st_idle;
			endcase
		end
	end

	// Strobe levels by style
	logic strobe_on;
	logic is_read;
	assign strobe_on = (state == st_strobe);
	assign is_read = (kind == host_bus_pkg::acc_read);
	always_ff @(posedge clock) begin
		if (reset) begin
			bus.chip_select_n <= 1'b1;
			bus.cmd_data_select <= 1'b0;
			bus.read_strobe <= 1'b1;
			bus.write_strobe <= 1'b1;
			bus.host_data_out <= 8'h00;
			bus.host_data_oe <= 1'b0;
		end else begin
			bus.chip_select_n <= (state == st_idle);
			bus.cmd_data_select <= (kind != host_bus_pkg::acc_data_write); // RULE3 RULE4 RULE5
			bus.host_data_out <= wdata;
			bus.host_data_oe <= (state != st_idle) && !is_read;
			unique case (bus_config_straps)
				`STYLE_ENABLE: begin
					bus.read_strobe <= is_read; // RULE7
					bus.write_strobe <= strobe_on; // RULE7
				end
				`STYLE_DSTROBE: begin
					bus.read_strobe <= is_read; // RULE8
					bus.write_strobe <= !strobe_on; // RULE8
				end
				default: begin
					bus.read_strobe <= !(strobe_on && is_read); // RULE6
					bus.write_strobe <= !(strobe_on && !is_read); // RULE6
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			done <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			done <= (state == st_strobe) && (count == 8'h01);
			if (state == st_strobe && count == 8'h01 && is_read && bus.dev_data_oe)
				rsp_data <= bus.dev_data_out; // RULE4
		end
	end
endmodule

/* File: sim/host_bus_access_decoder_assertions.sv */
// Purpose: Pin-level checks of the host port
// Assumes: Straps change only under reset
// Notes: Sees only interface pins and the straps
`timescale 1ns/1ps
module host_bus_access_decoder_assertions (
	input wire logic clock,
	input wire logic reset,
	input wire logic [2:0] bus_config_straps,
	input wire logic chip_select_n,
	input wire logic cmd_data_select,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic host_data_oe,
	input wire logic dev_data_oe
);
	// ----------------
	// Decoded strobes
	// ----------------
	wire logic gen = bus_config_straps != 3'h1 && bus_config_straps != 3'h2;
	wire logic en_on = bus_config_straps == 3'h1 ? write_strobe : !write_strobe;
	wire logic rd_on = gen ? !read_strobe && write_strobe : en_on && read_strobe;
	wire logic wr_on = gen ? read_strobe && !write_strobe : en_on && !read_strobe;
	wire logic act = rd_on || wr_on;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	idle_after_reset_a: assert property ($fell(reset) |-> chip_select_n && !dev_data_oe)
		else $error("pins not idle after reset");
	setup_first_a: assert property ($fell(chip_select_n) |-> !act)
		else $error("strobe before select");
	generic_excl_a: assert property (gen && !chip_select_n |-> read_strobe || write_strobe)
		else $error("both generic strobes low");
	read_select_a: assert property (rd_on && !chip_select_n |-> cmd_data_select)
		else $error("read with select low");
	write_drive_a: assert property (wr_on && !chip_select_n |-> host_data_oe && !dev_data_oe)
		else $error("write data not driven");
	strobe_width_a: assert property ($rose(act) |-> act [*6])
		else $error("strobe too short");
	strobe_gap_a: assert property ($fell(act) |-> !act [*3])
		else $error("strobe gap too short");
	oe_cause_a: assert property ($rose(dev_data_oe) |-> $past(rd_on && !chip_select_n && cmd_data_select, 3))
		else $error("device drove without read");
	oe_release_a: assert property ($fell(rd_on) |-> ##[0:5] !dev_data_oe)
		else $error("device kept driving");
	cover property (gen && wr_on);
	cover property (bus_config_straps == 3'h1 && rd_on);
	cover property (bus_config_straps == 3'h2 && wr_on);
	cover property ($rose(dev_data_oe));
endmodule

/* File: sim/host_bus_access_decoder_tb_top.sv */
// Purpose: Runs both port ends against a count model
// Assumes: Master keeps access spacing
// Notes: Each style gets its own reset
`timescale 1ns/1ps
module host_bus_access_decoder_tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	logic [2:0] bus_config_straps = 3'h0;
	logic [7:0] read_data = 8'h00;
	logic [7:0] req_data = 8'h00;
	host_bus_pkg::access_e req_kind = host_bus_pkg::acc_none;
	logic req_ready, done, read_pulse, data_write_pulse, cmd_write_pulse;
	logic [7:0] rsp_data, write_data;
	int error_cnt = 0;
	int tests_run = 0;
	int seen[3] = '{0, 0, 0};
	int want[3] = '{0, 0, 0};
	int seed;
	host_bus_if bus ();
	host_bus_decoder host_bus_decoder_inst (.clock(clock), .reset(reset), .bus_config_straps(bus_config_straps),
		.bus(bus.device), .read_data(read_data), .read_pulse(read_pulse), .data_write_pulse(data_write_pulse),
		.cmd_write_pulse(cmd_write_pulse), .write_data(write_data));
	host_bus_master host_bus_master_inst (.clock(clock), .reset(reset), .bus_config_straps(bus_config_straps),
		.bus(bus.host), .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
		.req_data(req_data), .done(done), .rsp_data(rsp_data));
	host_bus_access_decoder_assertions chk (.clock(clock), .reset(reset), .bus_config_straps(bus_config_straps),
		.chip_select_n(bus.chip_select_n), .cmd_data_select(bus.cmd_data_select), .read_strobe(bus.read_strobe),
		.write_strobe(bus.write_strobe), .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));
	always #5 clock = ~clock;
	always @(posedge clock) begin
		seen[0] <= seen[0] + int'(read_pulse === 1'b1);
		seen[1] <= seen[1] + int'(data_write_pulse === 1'b1);
		seen[2] <= seen[2] + int'(cmd_write_pulse === 1'b1);
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic check(logic [7:0] got, logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic access(host_bus_pkg::access_e k, logic [7:0] d, logic [7:0] rd);
		int n;
		@(posedge clock);
		read_data <= rd;
		req_kind <= k;
		req_data <= d;
		req_valid <= 1'b1;
		#1;
		for (n = 0; n < 40 && req_ready !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (done !== 1'b1 && n < 40);
		// Done stands one cycle only, so look before waiting
		check({7'h0, done}, 8'h01);
		#20;
		if (k == host_bus_pkg::acc_read) begin
			want[0]++;
			check(rsp_data, rd);
		end else begin
			want[int'(k) - 1]++;
			check(write_data, d);
		end
		for (int j = 0; j < 3; j++) check(8'(seen[j]), 8'(want[j]));
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		seed = $urandom(32'h0946);
		for (int s = 0; s < 3; s++) begin
			@(posedge clock);
			reset <= 1'b1;
			bus_config_straps <= 3'(s);
			repeat (6) @(posedge clock);
			reset <= 1'b0;
			for (int i = 0; i < 9; i++) access(host_bus_pkg::access_e'(i % 3 + 1), 8'($urandom), 8'($urandom));
			$display("style %0d finished", s);
		end
		end_of_test;
	end
	initial begin
		repeat (4000) @(posedge clock);
		error_cnt++;
		end_of_test;
	end
endmodule
